// ---- logic/cfbf_consts.vh ----
/*
 constants for the compressed field bitstream framer: marker codes,
 the later-block count and the type field width.
 assumes the includer uses these in a single clock domain.
*/
`ifndef CFBF_CONSTS_VH
`define CFBF_CONSTS_VH

// marker codes in the type field of a stream word (values arbitrary)
`define CFBF_TYPE_W 4
`define CFBF_MK_FIELD1 4'h1
`define CFBF_MK_FIELD2 4'h2
`define CFBF_MK_BLK1 4'h3
`define CFBF_MK_BLK2 4'h4
`define CFBF_MK_BLK3 4'h5
`define CFBF_MK_BLK4 4'h6
`define CFBF_MK_ZERO 4'h7
`define CFBF_MK_END 4'h8
`define CFBF_MK_FIRST 4'h9
`define CFBF_MK_DATA 4'h0

// block records after the first block of a field
`define CFBF_LATER_BLOCKS 41

`endif

// ---- logic/cfbf_framer.v ----
/*
 compressed field bitstream framer: builds the field record stream in
 encode and checks/parses it in decode.
 assumes a word-wide stream with valid/ready on both sides and a host
 that ends a decode sequence with the end marker.
*/
// Functional notes
// - encode sends stream; decode accepts same.
// - fields alternate first then second, unbounded.
// - field marker, timecode, first block, blocks.
// - first block: tag, bin width, payload.
// - exactly 41 later blocks per field.
// - later block: marker, bin width, payload.
// - zero-block marker accepted for any block.
`timescale 1ns/100ps
`include "cfbf_consts.vh"

module cfbf_framer #(
  parameter DATA_W = 32,
  parameter BW_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // mode: 1 encode, 0 decode
  input wire encode_i,
  // encode side: payload words from the codec datapath
  input wire enc_valid_i,
  output wire enc_ready_o,
  input wire [`CFBF_TYPE_W-1:0] enc_marker_i,
  input wire [BW_W-1:0] enc_bw_i,
  input wire [DATA_W-1:0] enc_data_i,
  input wire enc_last_i,
  input wire enc_zero_i,
  // host stream out (encode)
  output reg tx_valid_o,
  input wire tx_ready_i,
  output reg [`CFBF_TYPE_W-1:0] tx_type_o,
  output reg [DATA_W-1:0] tx_data_o,
  // host stream in (decode)
  input wire rx_valid_i,
  output wire rx_ready_o,
  input wire [`CFBF_TYPE_W-1:0] rx_type_i,
  input wire [DATA_W-1:0] rx_data_i,
  // decoded fields toward the datapath
  output reg dec_valid_o,
  input wire dec_ready_i,
  output reg [DATA_W-1:0] dec_data_o,
  output reg [BW_W-1:0] dec_bw_o,
  output reg [5:0] dec_block_o,
  output reg dec_zero_o,
  // status
  output reg [1:0] field_o,
  output reg seq_end_o,
  output reg error_o
);

  // ==========================================================
  // states
  localparam S_MARK = 3'd0;
  localparam S_TC = 3'd1;
  localparam S_BW = 3'd2;
  localparam S_DATA = 3'd3;
  localparam S_BLKM = 3'd4;
  localparam S_END = 3'd5;

  function is_later_marker;
    input [`CFBF_TYPE_W-1:0] t;
    begin
      is_later_marker = (t == `CFBF_MK_BLK1) || (t == `CFBF_MK_BLK2) ||
                        (t == `CFBF_MK_BLK3) || (t == `CFBF_MK_BLK4) ||
                        (t == `CFBF_MK_ZERO);
    end
  endfunction

  localparam [5:0] LAST_BLK = `CFBF_LATER_BLOCKS;

  reg [2:0] st_q;
  reg [5:0] blk_q;
  reg second_q;
  reg zero_q;

  // ==========================================================
  // handshakes
  wire tx_free = !tx_valid_o || tx_ready_i;
  assign enc_ready_o = encode_i && tx_free && (st_q == S_DATA);
  assign rx_ready_o = !encode_i && (!dec_valid_o || dec_ready_i) &&
                      (st_q != S_END);
  wire rx_go = rx_valid_i && rx_ready_o;

  // ==========================================================
  // encode: inserts markers, timecode, bin width around payload
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_type_o <= `CFBF_MK_DATA;
      tx_data_o <= {DATA_W{1'b0}};
    end else if (tx_free) begin
      tx_valid_o <= 1'b0;
      if (encode_i && st_q != S_DATA) begin
        tx_valid_o <= 1'b1;
        tx_data_o <= {DATA_W{1'b0}};
        case (st_q)
          S_MARK: tx_type_o <= second_q ? `CFBF_MK_FIELD2 :
                               `CFBF_MK_FIELD1;
          S_TC: begin
            tx_type_o <= `CFBF_MK_DATA;
            tx_data_o <= enc_data_i;
          end
          S_BLKM: tx_type_o <= blk_q == 6'd0 ? `CFBF_MK_FIRST :
                               (enc_zero_i ? `CFBF_MK_ZERO :
                               enc_marker_i);
          S_BW: begin
            tx_type_o <= `CFBF_MK_DATA;
            tx_data_o <= {{(DATA_W-BW_W){1'b0}}, enc_bw_i};
          end
          default: tx_valid_o <= 1'b0;
        endcase
      end else if (enc_valid_i && enc_ready_o) begin
        tx_valid_o <= 1'b1;
        tx_type_o <= `CFBF_MK_DATA;
        tx_data_o <= enc_data_i;
      end
    end
  end

  // ==========================================================
  // record sequencer shared by both directions
  wire enc_step = encode_i && tx_free && st_q != S_DATA;
  wire enc_last = enc_valid_i && enc_ready_o && enc_last_i;
  wire [`CFBF_TYPE_W-1:0] rt = rx_type_i;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= S_MARK;
      blk_q <= 6'd0;
      second_q <= 1'b0;
      zero_q <= 1'b0;
      field_o <= 2'd0;
      seq_end_o <= 1'b0;
      error_o <= 1'b0;
    end else if (encode_i) begin
      case (st_q)
        S_MARK: if (enc_step) begin
          st_q <= S_TC;
          field_o <= second_q ? 2'd2 : 2'd1;
        end
        S_TC: if (enc_step) begin
          st_q <= S_BLKM;
          blk_q <= 6'd0;
        end
        S_BLKM: if (enc_step) st_q <= S_BW;
        S_BW: if (enc_step) st_q <= S_DATA;
        S_DATA: if (enc_last) begin
          if (blk_q == LAST_BLK) begin
            st_q <= S_MARK;
            second_q <= !second_q;
          end else begin
            st_q <= S_BLKM;
            blk_q <= blk_q + 6'd1;
          end
        end
        default: st_q <= S_MARK;
      endcase
    end else if (rx_go) begin
      error_o <= 1'b0;
      case (st_q)
        S_MARK: begin
          if (rt == `CFBF_MK_END) begin
            st_q <= S_END;
            seq_end_o <= 1'b1;
          end else if (rt == (second_q ? `CFBF_MK_FIELD2 :
                                         `CFBF_MK_FIELD1)) begin
            st_q <= S_TC;
            field_o <= second_q ? 2'd2 : 2'd1;
          end else
            error_o <= 1'b1;
        end
        S_TC: begin
          st_q <= S_BLKM;
          blk_q <= 6'd0;
        end
        S_BLKM: begin
          if ((blk_q == 6'd0 && (rt == `CFBF_MK_FIRST ||
              rt == `CFBF_MK_ZERO)) ||
              (blk_q != 6'd0 && is_later_marker(rt))) begin
            st_q <= S_BW;
            zero_q <= (rt == `CFBF_MK_ZERO);
          end else begin
            error_o <= 1'b1;
            st_q <= S_MARK;
          end
        end
        S_BW: st_q <= S_DATA;
        S_DATA: begin
          if (rt != `CFBF_MK_DATA) begin
            if (blk_q == LAST_BLK) begin
              second_q <= !second_q;
              if (rt == `CFBF_MK_END) begin
                st_q <= S_END;
                seq_end_o <= 1'b1;
              end else if (rt == (second_q ? `CFBF_MK_FIELD1 :
                                             `CFBF_MK_FIELD2)) begin
                st_q <= S_TC;
                field_o <= second_q ? 2'd1 : 2'd2;
              end else begin
                st_q <= S_MARK;
                error_o <= 1'b1;
              end
            end else if (is_later_marker(rt)) begin
              blk_q <= blk_q + 6'd1;
              zero_q <= (rt == `CFBF_MK_ZERO);
              st_q <= S_BW;
            end else begin
              st_q <= S_MARK;
              error_o <= 1'b1;
            end
          end
        end
        default: st_q <= S_MARK;
      endcase
    end else if (st_q == S_END && rx_valid_i == 1'b0) begin
      st_q <= S_MARK; // new sequence restarts at the first field
      second_q <= 1'b0;
      seq_end_o <= 1'b0;
    end
  end

  // ==========================================================
  // decode output: payload words with the block's bin width
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dec_valid_o <= 1'b0;
      dec_data_o <= {DATA_W{1'b0}};
      dec_bw_o <= {BW_W{1'b0}};
      dec_block_o <= 6'd0;
      dec_zero_o <= 1'b0;
    end else begin
      if (dec_ready_i)
        dec_valid_o <= 1'b0;
      if (rx_go && st_q == S_BW)
        dec_bw_o <= rx_data_i[BW_W-1:0];
      if (rx_go && st_q == S_DATA && rt == `CFBF_MK_DATA) begin
        dec_valid_o <= 1'b1;
        dec_data_o <= rx_data_i;
        dec_block_o <= blk_q;
        dec_zero_o <= zero_q;
      end
    end
  end

endmodule // cfbf_framer

// ---- test/cfbf_props.sv ----
/* port checker for the framer
 assumes it is bound onto every cfbf_framer */
`timescale 1ns/100ps
`include "cfbf_consts.vh"
module cfbf_props #(
  parameter DATA_W = 32
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // watched ports
  input wire encode_i,
  input wire rx_ready_o,
  input wire tx_valid_o,
  input wire tx_ready_i,
  input wire [3:0] tx_type_o,
  input wire [DATA_W-1:0] tx_data_o,
  input wire dec_valid_o,
  input wire dec_ready_i,
  input wire [DATA_W-1:0] dec_data_o,
  input wire [5:0] dec_block_o,
  input wire [1:0] field_o
);
  // ==========================================
  // assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable({tx_type_o, tx_data_o})) else $error("tx lost");
  dec_hold_a: assert property (dec_valid_o && !dec_ready_i |=>
    dec_valid_o && $stable(dec_data_o)) else $error("dec lost");
  rx_refuse_a: assert property (encode_i |-> !rx_ready_o)
    else $error("rx taken in encode");
  tx_code_a: assert property (tx_valid_o |-> tx_type_o <= 4'h9)
    else $error("bad tx code");
  tag_then_bw_a: assert property (tx_valid_o && tx_ready_i &&
    tx_type_o != `CFBF_MK_DATA |=> !tx_valid_o || tx_type_o == 4'h0)
    else $error("marker not followed by data");
  blk_range_a: assert property (dec_valid_o |-> dec_block_o <= 6'd41)
    else $error("block index too large");
  field_code_a: assert property (field_o != 2'd3)
    else $error("bad field number");
endmodule // cfbf_props

bind cfbf_framer cfbf_props #(.DATA_W(DATA_W)) u_props (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .encode_i(encode_i), .rx_ready_o(rx_ready_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_type_o(tx_type_o),
  .tx_data_o(tx_data_o), .dec_valid_o(dec_valid_o),
  .dec_ready_i(dec_ready_i), .dec_data_o(dec_data_o),
  .dec_block_o(dec_block_o), .field_o(field_o));

// ---- test/cfbf_host_model.sv ----
/* host model: feeds the decode stream, paces the encode stream
 assumes the bench queues words through send */
`timescale 1ns/100ps
module cfbf_host_model (
  // clock
  input wire clk_i,
  // stream toward the framer
  output reg rx_valid_o,
  output reg [3:0] rx_type_o,
  output reg [31:0] rx_data_o,
  input wire rx_ready_i,
  // encode pacing
  output reg tx_ready_o
);
  reg [35:0] q[$];
  reg took = 1'b0;
  integer seed = 32'h0569_d6af;
  initial {rx_valid_o, rx_type_o, rx_data_o, tx_ready_o} = 38'h0;
  task send(input [3:0] t, input [31:0] d);
    q.push_back({t, d});
  endtask
  always @(posedge clk_i) took <= rx_valid_o && rx_ready_i;
  // ==========================================
  // word held until taken, released lines toggle
  always @(negedge clk_i) begin
    tx_ready_o <= $random(seed) % 2 != 0;
    if (!rx_valid_o || took) begin
      if (q.size() && $random(seed) % 3 != 0) begin
        {rx_type_o, rx_data_o} <= q.pop_front();
        rx_valid_o <= 1'b1;
      end else begin
        rx_valid_o <= 1'b0;
        {rx_type_o, rx_data_o} <= ~{rx_type_o, rx_data_o};
      end
    end
  end
endmodule // cfbf_host_model

// ---- test/test_compressed_field_bitstream_framer.sv ----
/* bench: two decoded fields then two encoded fields
 assumes cfbf_host_model on the host side */
`timescale 1ns/100ps
`include "cfbf_consts.vh"
module test_compressed_field_bitstream_framer;
  reg clk_i = 0, arst_n_i = 0, encode_i = 0, enc_valid_i = 0;
  reg enc_last_i = 0, enc_zero_i = 0, dec_ready_i = 0;
  reg [3:0] enc_marker_i = 4'h0;
  reg [15:0] enc_bw_i = 16'h0c2e;
  reg [31:0] enc_data_i = 32'h0000_0000;
  wire enc_ready_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o;
  wire dec_valid_o, dec_zero_o, seq_end_o, error_o;
  wire [3:0] tx_type_o, rx_type_i;
  wire [31:0] tx_data_o, rx_data_i, dec_data_o;
  wire [15:0] dec_bw_o;
  wire [5:0] dec_block_o;
  wire [1:0] field_o;
  integer n_errors = 0, compares = 0, seed = 32'h0569_d6af, i, w;
  reg [54:0] exp_q[$];
  reg [4:0] typ_q[$];
  reg [4:0] te;
  reg end_seen = 0;
  cfbf_framer dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .encode_i(encode_i),
    .enc_valid_i(enc_valid_i), .enc_ready_o(enc_ready_o),
    .enc_marker_i(enc_marker_i), .enc_bw_i(enc_bw_i),
    .enc_data_i(enc_data_i), .enc_last_i(enc_last_i),
    .enc_zero_i(enc_zero_i), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .tx_type_o(tx_type_o), .tx_data_o(tx_data_o),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
    .rx_type_i(rx_type_i), .rx_data_i(rx_data_i),
    .dec_valid_o(dec_valid_o), .dec_ready_i(dec_ready_i),
    .dec_data_o(dec_data_o), .dec_bw_o(dec_bw_o),
    .dec_block_o(dec_block_o), .dec_zero_o(dec_zero_o),
    .field_o(field_o), .seq_end_o(seq_end_o), .error_o(error_o));
  cfbf_host_model host (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
    .rx_type_o(rx_type_i), .rx_data_o(rx_data_i),
    .rx_ready_i(rx_ready_o), .tx_ready_o(tx_ready_i));
  initial forever #12.5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    dec_ready_i <= $random(seed) % 2 != 0;
    enc_data_i <= $random(seed);
  end
  // ==========================================
  // checking
  task chk(input [63:0] nm, input [54:0] e, input [54:0] s);
    begin
      compares = compares + 1;
      if (e !== s) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task conclude;
    begin
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    if (seq_end_o)
      end_seen <= 1'b1;
    if (dec_valid_o && dec_ready_i) begin
      if (exp_q.size())
        chk("dec", exp_q.pop_front(),
          {dec_block_o, dec_zero_o, dec_bw_o, dec_data_o});
      else
        chk("dec xtra", 55'h0, 55'h1);
    end
    if (tx_valid_o && tx_ready_i && typ_q.size()) begin
      te = typ_q.pop_front();
      chk("tx type", {51'h0, te[3:0]}, {51'h0, tx_type_o});
      if (te[4])
        chk("tx bw", {39'h0, enc_bw_i}, {23'h0, tx_data_o});
    end
    if (arst_n_i && error_o !== 1'b0)
      chk("error", 55'h0, {54'h0, error_o});
  end
  // ==========================================
  // stimulus
  task blk(input [3:0] t, input [5:0] b);
    reg [15:0] bw;
    reg [31:0] d;
    begin
      bw = $random(seed);
      d = $random(seed);
      host.send(t, 32'h0000_0000);
      host.send(`CFBF_MK_DATA, {bw, bw});
      host.send(`CFBF_MK_DATA, d);
      exp_q.push_back({b, t == `CFBF_MK_ZERO, bw, d});
    end
  endtask
  task field(input [3:0] f, input [3:0] t0);
    begin
      host.send(f, $random(seed));
      host.send(`CFBF_MK_DATA, $random(seed));
      blk(t0, 6'd0);
      for (i = 1; i <= 41; i = i + 1) begin
        w = $unsigned($random(seed)) % 5;
        blk(`CFBF_MK_BLK1 + w[3:0], i[5:0]);
      end
    end
  endtask
  task drain;
    begin
      w = 0;
      while ((exp_q.size() || typ_q.size() || host.q.size()) && w < 4000)
        @(negedge clk_i) w = w + 1;
      if (w >= 4000) begin
        chk("timeout", 55'h0, 55'h1);
        conclude;
      end
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    arst_n_i = 1;
    field(`CFBF_MK_FIELD1, `CFBF_MK_FIRST);
    field(`CFBF_MK_FIELD2, `CFBF_MK_ZERO);
    host.send(`CFBF_MK_END, 32'h0000_0000);
    drain;
    repeat (4) @(negedge clk_i);
    chk("field", 55'h2, {53'h0, field_o});
    chk("seq end", 55'h1, {54'h0, end_seen});
    $display("decode test done");
    encode_i = 1;
    enc_valid_i = 1;
    enc_last_i = 1;
    enc_marker_i = `CFBF_MK_BLK2;
    for (w = 1; w <= 2; w = w + 1) begin
      typ_q.push_back({1'b0, w[3:0]});
      typ_q.push_back({1'b0, `CFBF_MK_DATA});
      typ_q.push_back({1'b0, `CFBF_MK_FIRST});
      for (i = 0; i < 125; i = i + 1)
        typ_q.push_back({i % 3 == 0, i % 3 != 2 ? `CFBF_MK_DATA :
          (w == 2 ? `CFBF_MK_ZERO : `CFBF_MK_BLK2)});
    end
    w = 0;
    while (typ_q.size() > 128 && w < 4000)
      @(negedge clk_i) w = w + 1;
    enc_zero_i = 1;
    drain;
    $display("encode test done");
    conclude;
  end
endmodule // test_compressed_field_bitstream_framer
